// file: src/upef_defs.svh
`ifndef UPEF_DEFS_SVH
`define UPEF_DEFS_SVH

// register offsets on the special-function register port
`define UPEF_ADDR_PORT2_LATCH   8'ha0
`define UPEF_ADDR_PORT2_MODE    8'ha6
`define UPEF_ADDR_PORT3_MODE    8'ha7
`define UPEF_ADDR_EDGE_PENDING  8'had
`define UPEF_ADDR_PORT3_LATCH   8'hb0

// reset values
`define UPEF_RST_LATCH          8'hff
`define UPEF_RST_MODE           8'h00
`define UPEF_RST_EDGE_PENDING   4'h0
`define UPEF_RST_PIN_LEVEL      1'b1

// edge-flag field of the pending register
`define UPEF_EDGE_LSB           4
`define UPEF_EDGE_MSB           7
`define UPEF_EDGE_UNUSED        4'h0

// value returned for an unmapped offset
`define UPEF_RDATA_UNMAPPED     8'h00

`endif

// file: src/upef_pkg.sv
package upef_pkg;

  typedef logic [7:0] upef_byte_type;

  typedef struct packed {
    upef_byte_type port2_latch;
    upef_byte_type port3_latch;
    upef_byte_type port2_drive_mode;
    upef_byte_type port3_drive_mode;
    upef_byte_type rdata;
    logic          rvalid;
    upef_byte_type port2_out;
    upef_byte_type port2_oe;
    upef_byte_type port3_out;
    upef_byte_type port3_oe;
    upef_byte_type port2_pullup;
    upef_byte_type port3_pullup;
  } upef_top_state_type;

endpackage

// file: src/upef_pin_sync.sv
`timescale 1ns/1ps
`include "upef_defs.svh"

module upef_pin_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // raw pins and settled level
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  import upef_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } upef_sync_state_type;

  upef_sync_state_type q;
  upef_sync_state_type d;
  logic [W-1:0]        agree;

  always_comb begin
    d     = q;
    agree = ~(q.s2 ^ q.s3);
    d.s1  = pin;
    d.s2  = q.s1;
    d.s3  = q.s2;
    // a level only moves once two settled stages agree
    d.lvl = (q.s3 & agree) | (q.lvl & ~agree);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= {(4 * W){`UPEF_RST_PIN_LEVEL}};
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;

endmodule

// file: src/upef_edge_flags.sv
`timescale 1ns/1ps
`include "upef_defs.svh"

module upef_edge_flags #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // settled pin level and software clear
  input  wire logic [W-1:0] level,
  input  wire logic [W-1:0] clear,
  // sticky pending flags
  output logic      [W-1:0] pending
);
  import upef_pkg::*;

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] flags;
  } upef_edge_state_type;

  upef_edge_state_type q;
  upef_edge_state_type d;
  logic [W-1:0]        fall;

  always_comb begin
    d       = q;
    fall    = q.prev & ~level;
    d.prev  = level;
    // a new edge beats a clear in the same cycle
    d.flags = (q.flags & ~clear) | fall;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q.prev  <= {W{`UPEF_RST_PIN_LEVEL}};
      q.flags <= {W{1'b0}};
    end else begin
      q <= d;
    end
  end

  assign pending = q.flags;

  a_edge_sets: assert property (
    @(posedge clk) disable iff (rst)
    (|fall) |=> ((pending & $past(fall)) == $past(fall)))
    else $error("falling edge did not set its flag");

  a_clear_loses: assert property (
    @(posedge clk) disable iff (rst)
    (|(clear & fall)) |=> (|(pending & $past(clear & fall))))
    else $error("clear beat a same-cycle edge");

  a_no_spurious: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> ((pending & ~$past(pending | fall)) == '0))
    else $error("flag set without a falling edge");

endmodule

// file: src/upef_top.sv
`timescale 1ns/1ps
`include "upef_defs.svh"

// Function
// - hardware sets pending flag n on a falling edge at port 1 pin n
// - low four pending bits read zero and ignore writes
// - port 2 writes are latched and driven as the crossbar routes them
// - port 2: a 0 to drive (latch or crossbar bit) drives low; 1 drives high or floats per mode
// - port 2 reads return pin levels regardless of crossbar
// - port 2 mode bit: 0 open-drain, 1 push-pull
// - port 3: written 0 drives low; 1 drives high or floats per mode
// - port 3 reads return the sensed pin levels
// - port 3 mode bit: 0 open-drain, 1 push-pull
// - read-modify-write reads the latch, not the pins
// - weak pull-ups on non push-pull pins unless globally disabled
module upef_top (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // special-function register port
  input  wire upef_pkg::upef_byte_type sfr_addr,
  input  wire logic                   sfr_wr,
  input  wire upef_pkg::upef_byte_type sfr_wdata,
  input  wire logic                   sfr_rd,
  input  wire logic                   sfr_rmw,
  output upef_pkg::upef_byte_type     sfr_rdata,
  output logic                        sfr_rvalid,
  // crossbar claims on port 2 and global pull-up control
  input  wire upef_pkg::upef_byte_type port2_xbar_take,
  input  wire upef_pkg::upef_byte_type port2_xbar_data,
  input  wire logic                   weak_pullup_disable,
  // port 1 edge pins, bits 7 down to 4
  input  wire logic [3:0]             port1_upper_pin_in,
  output logic [3:0]                  port1_edge_pending,
  // port 2 pins
  input  wire upef_pkg::upef_byte_type port2_pin_in,
  output upef_pkg::upef_byte_type     port2_pin_out,
  output upef_pkg::upef_byte_type     port2_pin_oe,
  output upef_pkg::upef_byte_type     port2_pullup_en,
  // port 3 pins
  input  wire upef_pkg::upef_byte_type port3_pin_in,
  output upef_pkg::upef_byte_type     port3_pin_out,
  output upef_pkg::upef_byte_type     port3_pin_oe,
  output upef_pkg::upef_byte_type     port3_pullup_en
);
  import upef_pkg::*;

  localparam upef_top_state_type RST_STATE = '{
    port2_latch:      `UPEF_RST_LATCH,
    port3_latch:      `UPEF_RST_LATCH,
    port2_drive_mode: `UPEF_RST_MODE,
    port3_drive_mode: `UPEF_RST_MODE,
    rdata:            `UPEF_RDATA_UNMAPPED,
    rvalid:           1'b0,
    port2_out:        `UPEF_RST_LATCH,
    port2_oe:         ~`UPEF_RST_LATCH | `UPEF_RST_MODE,
    port3_out:        `UPEF_RST_LATCH,
    port3_oe:         ~`UPEF_RST_LATCH | `UPEF_RST_MODE,
    port2_pullup:     ~`UPEF_RST_MODE,
    port3_pullup:     ~`UPEF_RST_MODE
  };

  function automatic logic hit(input upef_byte_type a,
                               input upef_byte_type target);
    hit = (a == target);
  endfunction

  // a latched 0 always drives; a 1 drives only when push-pull
  function automatic upef_byte_type drive_en(input upef_byte_type val,
                                             input upef_byte_type mode);
    drive_en = ~val | mode;
  endfunction

  upef_top_state_type q;
  upef_top_state_type d;
  upef_byte_type      port2_level;
  upef_byte_type      port3_level;
  logic [3:0]         edge_level;
  logic [3:0]         edge_pending;
  logic [3:0]         edge_clear;
  upef_byte_type      port2_drive;
  upef_byte_type      pullup_gate;

  // pins come from outside the clock domain
  upef_pin_sync #(
    .W (8)
  ) u_sync_port2 (
    .clk   (clk),
    .rst   (rst),
    .pin   (port2_pin_in),
    .level (port2_level)
  );

  upef_pin_sync #(
    .W (8)
  ) u_sync_port3 (
    .clk   (clk),
    .rst   (rst),
    .pin   (port3_pin_in),
    .level (port3_level)
  );

  upef_pin_sync #(
    .W (4)
  ) u_sync_port1 (
    .clk   (clk),
    .rst   (rst),
    .pin   (port1_upper_pin_in),
    .level (edge_level)
  );

  // software clears a flag by writing 0 to it; 1 leaves it alone
  assign edge_clear = (sfr_wr && hit(sfr_addr, `UPEF_ADDR_EDGE_PENDING))
                      ? ~sfr_wdata[`UPEF_EDGE_MSB:`UPEF_EDGE_LSB]
                      : 4'h0;

  upef_edge_flags #(
    .W (4)
  ) u_edge_flags (
    .clk     (clk),
    .rst     (rst),
    .level   (edge_level),
    .clear   (edge_clear),
    .pending (edge_pending)
  );

  always_comb begin
    d = q;

    // register writes
    if (sfr_wr) begin
      if (hit(sfr_addr, `UPEF_ADDR_PORT2_LATCH)) begin
        d.port2_latch = sfr_wdata;
      end
      if (hit(sfr_addr, `UPEF_ADDR_PORT3_LATCH)) begin
        d.port3_latch = sfr_wdata;
      end
      if (hit(sfr_addr, `UPEF_ADDR_PORT2_MODE)) begin
        d.port2_drive_mode = sfr_wdata;
      end
      if (hit(sfr_addr, `UPEF_ADDR_PORT3_MODE)) begin
        d.port3_drive_mode = sfr_wdata;
      end
    end

    // crossbar-owned bits take the peripheral's value, drive rule unchanged
    port2_drive = (d.port2_latch & ~port2_xbar_take)
                | (port2_xbar_data & port2_xbar_take);
    d.port2_out = port2_drive;
    d.port2_oe  = drive_en(port2_drive, d.port2_drive_mode);
    d.port3_out = d.port3_latch;
    d.port3_oe  = drive_en(d.port3_latch, d.port3_drive_mode);

    // push-pull bits never get the weak pull-up
    pullup_gate    = {8{~weak_pullup_disable}};
    d.port2_pullup = pullup_gate & ~d.port2_drive_mode;
    d.port3_pullup = pullup_gate & ~d.port3_drive_mode;

    // reads answer one cycle later from a register
    d.rvalid = sfr_rd;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `UPEF_ADDR_PORT2_LATCH: begin
          // bit ops and logic ops must not fold pin levels back in
          d.rdata = sfr_rmw ? q.port2_latch : port2_level;
        end
        `UPEF_ADDR_PORT3_LATCH: begin
          d.rdata = sfr_rmw ? q.port3_latch : port3_level;
        end
        `UPEF_ADDR_PORT2_MODE: begin
          d.rdata = q.port2_drive_mode;
        end
        `UPEF_ADDR_PORT3_MODE: begin
          d.rdata = q.port3_drive_mode;
        end
        `UPEF_ADDR_EDGE_PENDING: begin
          d.rdata = {edge_pending, `UPEF_EDGE_UNUSED};
        end
        default: begin
          d.rdata = `UPEF_RDATA_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata          = q.rdata;
  assign sfr_rvalid         = q.rvalid;
  assign port1_edge_pending = edge_pending;
  assign port2_pin_out      = q.port2_out;
  assign port2_pin_oe       = q.port2_oe;
  assign port2_pullup_en    = q.port2_pullup;
  assign port3_pin_out      = q.port3_out;
  assign port3_pin_oe       = q.port3_oe;
  assign port3_pullup_en    = q.port3_pullup;

  a_port2_write: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_wr && sfr_addr == `UPEF_ADDR_PORT2_LATCH && port2_xbar_take == '0)
    |=> (port2_pin_out == $past(sfr_wdata)))
    else $error("port 2 write not driven to the pins");

  a_port2_drive: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_wr && sfr_addr == `UPEF_ADDR_PORT2_MODE)
    |=> (port2_pin_oe == (~port2_pin_out | $past(sfr_wdata))))
    else $error("port 2 output enable ignores the mode");

  a_port2_mode_rb: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_wr && sfr_addr == `UPEF_ADDR_PORT2_MODE) ##1
    (sfr_rd && sfr_addr == `UPEF_ADDR_PORT2_MODE && !sfr_wr)
    |=> (sfr_rvalid && sfr_rdata == $past(sfr_wdata, 2)))
    else $error("port 2 mode readback wrong");

  a_port3_write: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_wr && sfr_addr == `UPEF_ADDR_PORT3_LATCH)
    |=> (port3_pin_out == $past(sfr_wdata)
         && port3_pin_oe == (~$past(sfr_wdata) | q.port3_drive_mode)))
    else $error("port 3 write drive wrong");

  a_port2_pin_read: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_rd && !sfr_rmw && sfr_addr == `UPEF_ADDR_PORT2_LATCH)
    |=> (sfr_rvalid && sfr_rdata == $past(port2_level)))
    else $error("port 2 read not the pin level");

  a_port3_pin_read: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_rd && !sfr_rmw && sfr_addr == `UPEF_ADDR_PORT3_LATCH)
    |=> (sfr_rdata == $past(port3_level)))
    else $error("port 3 read not the pin level");

  a_rmw_latch: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_rd && sfr_rmw && sfr_addr == `UPEF_ADDR_PORT3_LATCH)
    |=> (sfr_rdata == $past(q.port3_latch)))
    else $error("read-modify-write returned pins");

  a_pullup_gate: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> (port2_pullup_en
              == ({8{~$past(weak_pullup_disable)}} & ~q.port2_drive_mode)))
    else $error("port 2 pull-up enable wrong");

  a_low_nibble: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_rd && sfr_addr == `UPEF_ADDR_EDGE_PENDING)
    |=> (sfr_rdata[3:0] == 4'h0
         && sfr_rdata[7:4] == $past(edge_pending)))
    else $error("pending register read wrong");

  a_rvalid_pulse: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> (sfr_rvalid == $past(sfr_rd)))
    else $error("read valid not one cycle after the read");

  a_rdata_holds: assert property (
    @(posedge clk) disable iff (rst)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");

  a_port2_rmw: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_rd && sfr_rmw && sfr_addr == `UPEF_ADDR_PORT2_LATCH)
    |=> (sfr_rdata == $past(q.port2_latch)))
    else $error("port 2 read-modify-write returned pins");

  a_xbar_drive: assert property (
    @(posedge clk) disable iff (rst)
    (port2_xbar_take == 8'hff)
    |=> (port2_pin_out == $past(port2_xbar_data)))
    else $error("crossbar value not driven on port 2");

  a_port3_drive: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_wr && sfr_addr == `UPEF_ADDR_PORT3_MODE)
    |=> (port3_pin_oe == (~port3_pin_out | $past(sfr_wdata))))
    else $error("port 3 output enable ignores the mode");

  a_port3_mode_rb: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_rd && sfr_addr == `UPEF_ADDR_PORT3_MODE)
    |=> (sfr_rdata == $past(q.port3_drive_mode)))
    else $error("port 3 mode readback wrong");

  a_port3_pullup: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |=> (port3_pullup_en
              == ({8{~$past(weak_pullup_disable)}} & ~q.port3_drive_mode)))
    else $error("port 3 pull-up enable wrong");

  // only a write with no edge in flight must end up clear
  a_flag_clears: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_wr && sfr_addr == `UPEF_ADDR_EDGE_PENDING && !sfr_wdata[7]
     && (edge_level[3] || !$past(edge_level[3])))
    |=> !port1_edge_pending[3])
    else $error("written 0 did not clear the pending flag");

  a_ones_keep: assert property (
    @(posedge clk) disable iff (rst)
    (sfr_wr && sfr_addr == `UPEF_ADDR_EDGE_PENDING
     && sfr_wdata[7:4] == 4'hf)
    |=> ((port1_edge_pending & $past(port1_edge_pending))
         == $past(port1_edge_pending)))
    else $error("writing 1 cleared a pending flag");

endmodule

// file: dv/upef_pad_model.sv
`timescale 1ns/1ps

module upef_pad_model (
  // clock
  input  wire logic       clk,
  // device drive
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] pull_en,
  // external driver
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // resolved pad level
  output logic      [7:0] pad
);
  logic [7:0] float_q = 8'h55;

  // undriven pads toggle every clock, so the pin filter never settles and a read returns the last settled level
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end

  assign pad = (oe & out) | (~oe & ext_en & ext_val)
             | (~oe & ~ext_en & pull_en)
             | (~oe & ~ext_en & ~pull_en & float_q);
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps

module testbench;
  import upef_pkg::*;
  logic          clk = 0;
  logic          rst = 1;
  logic          wr = 0;
  logic          rd = 0;
  logic          rmw = 0;
  logic          rvalid;
  logic          wpd = 0;
  upef_byte_type addr = 8'h00;
  upef_byte_type wdata = 8'h00;
  upef_byte_type rdata;
  upef_byte_type x_take = 8'h00;
  upef_byte_type x_data = 8'h00;
  logic [3:0]    p1_in = 4'hf;
  logic [3:0]    p1_pend;
  upef_byte_type p2_in, p2_out, p2_oe, p2_pu;
  upef_byte_type p3_in, p3_out, p3_oe, p3_pu;
  upef_byte_type ext3_en = 8'h00;
  int            err_total = 0;
  int            comparisons = 0;

  always #4 clk = ~clk;

  upef_top i_dut (.clk(clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_wdata(wdata), .sfr_rd(rd), .sfr_rmw(rmw), .sfr_rdata(rdata),
    .sfr_rvalid(rvalid), .port2_xbar_take(x_take),
    .port2_xbar_data(x_data), .weak_pullup_disable(wpd),
    .port1_upper_pin_in(p1_in), .port1_edge_pending(p1_pend),
    .port2_pin_in(p2_in), .port2_pin_out(p2_out), .port2_pin_oe(p2_oe),
    .port2_pullup_en(p2_pu), .port3_pin_in(p3_in),
    .port3_pin_out(p3_out), .port3_pin_oe(p3_oe),
    .port3_pullup_en(p3_pu));

  upef_pad_model i_pad2 (.clk(clk), .out(p2_out), .oe(p2_oe),
    .pull_en(p2_pu), .ext_en(8'h00), .ext_val(8'h00), .pad(p2_in));
  upef_pad_model i_pad3 (.clk(clk), .out(p3_out), .oe(p3_oe),
    .pull_en(p3_pu), .ext_en(ext3_en), .ext_val(8'h00), .pad(p3_in));

  task automatic summarize();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input upef_byte_type got, input upef_byte_type exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic sfr_write(input upef_byte_type a, input upef_byte_type d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rdc(input upef_byte_type a, input logic m,
                     input upef_byte_type exp);
    @(posedge clk);
    addr <= a;
    rmw <= m;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask

  task automatic wait_pend(input logic [3:0] e);
    int n;
    n = 0;
    while (p1_pend !== e && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({4'h0, p1_pend}, {4'h0, e});
    if (n == 20) summarize();
  endtask

  task automatic t_reset();
    rdc(8'ha6, 1'b0, 8'h00);
    rdc(8'ha7, 1'b0, 8'h00);
    rdc(8'had, 1'b0, 8'h00);
    rdc(8'ha0, 1'b1, 8'hff);
    rdc(8'hb0, 1'b1, 8'hff);
    rdc(8'ha0, 1'b0, 8'hff);
    chk(p2_pu, 8'hff);
    chk(p2_oe, 8'h00);
    rdc(8'h55, 1'b0, 8'h00);
  endtask

  task automatic t_port2();
    sfr_write(8'ha0, 8'h55);
    chk(p2_out, 8'h55);
    chk(p2_oe, 8'haa);
    repeat (6) @(posedge clk);
    rdc(8'ha0, 1'b0, 8'h55);
    sfr_write(8'ha6, 8'hff);
    chk(p2_oe, 8'hff);
    chk(p2_pu, 8'h00);
    @(posedge clk);
    x_take <= 8'hff;
    x_data <= 8'ha5;
    repeat (6) @(posedge clk);
    #1;
    chk(p2_out, 8'ha5);
    rdc(8'ha0, 1'b0, 8'ha5);
    rdc(8'ha0, 1'b1, 8'h55);
    @(posedge clk);
    x_take <= 8'h00;
    sfr_write(8'h55, 8'h12);
    rdc(8'ha6, 1'b0, 8'hff);
  endtask

  task automatic t_port3();
    @(posedge clk);
    wpd <= 1'b1;
    ext3_en <= 8'h0f;
    sfr_write(8'hb0, 8'h0f);
    chk(p3_out, 8'h0f);
    chk(p3_oe, 8'hf0);
    chk(p3_pu, 8'h00);
    repeat (6) @(posedge clk);
    rdc(8'hb0, 1'b0, 8'h00);
    @(posedge clk);
    wpd <= 1'b0;
    ext3_en <= 8'h00;
    repeat (2) @(posedge clk);
    #1;
    chk(p3_pu, 8'hff);
    sfr_write(8'ha7, 8'h0f);
    chk(p3_oe, 8'hff);
    chk(p3_pu, 8'hf0);
    repeat (6) @(posedge clk);
    rdc(8'hb0, 1'b0, 8'h0f);
    rdc(8'hb0, 1'b1, 8'h0f);
  endtask

  task automatic t_edge();
    @(posedge clk);
    p1_in <= 4'he;
    wait_pend(4'h1);
    rdc(8'had, 1'b0, 8'h10);
    sfr_write(8'had, 8'hff);
    rdc(8'had, 1'b0, 8'h10);
    @(posedge clk);
    p1_in <= 4'h0;
    wait_pend(4'hf);
    sfr_write(8'had, 8'h00);
    chk({4'h0, p1_pend}, 8'h00);
    repeat (8) @(posedge clk);
    rdc(8'had, 1'b0, 8'h00);
    @(posedge clk);
    p1_in <= 4'hf;
  endtask

  // clearing write lands in the very cycle the pin 7 edge is detected
  task automatic t_race();
    repeat (6) @(posedge clk);
    p1_in <= 4'h7;
    repeat (3) @(posedge clk);
    sfr_write(8'had, 8'h00);
    chk({4'h0, p1_pend}, 8'h08);
    rdc(8'had, 1'b0, 8'h80);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_port2();
    t_port3();
    t_edge();
    t_race();
    summarize();
  end
endmodule
